// File: design/fsq_edge.sv
// Module: rising edge detector for synchronous level inputs
`timescale 1ns/1ps
module fsq_edge #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] sig_i,
    output logic      [W-1:0] rise_o
);
    typedef struct packed {
        logic [W-1:0] prev;
    } fsq_edge_st_t;

    fsq_edge_st_t q;
    fsq_edge_st_t d;

    if (W < 1) begin : g_bad_w
        $error("fsq_edge: W must be at least 1");
    end

    always_comb begin
        d      = q;
        d.prev = sig_i;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rise_o = sig_i & ~q.prev;
endmodule : fsq_edge

// File: design/fsq_irq.sv
// Module: sticky event status, mask and level interrupt
`timescale 1ns/1ps
module fsq_irq #(
    parameter int N = 4
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [N-1:0] set_i,
    input  wire logic         rd_clr_i,
    input  wire logic [N-1:0] clr_mask_i,
    input  wire logic         mask_wr_i,
    input  wire logic [N-1:0] mask_i,
    output logic      [N-1:0] stat_o,
    output logic      [N-1:0] mask_o,
    output logic              irq_o
);
    typedef struct packed {
        logic [N-1:0] stat;
        logic [N-1:0] mask;
        logic         irq;
    } fsq_irq_st_t;

    fsq_irq_st_t q;
    fsq_irq_st_t d;

    if (N < 1 || N > 32) begin : g_bad_n
        $error("fsq_irq: N must be 1 to 32");
    end

    always_comb begin
        d = q;
        // Only bits that the read returned are cleared; a set wins
        d.stat = (q.stat & ~(rd_clr_i ? clr_mask_i : '0)) | set_i;
        if (mask_wr_i) begin
            d.mask = mask_i;
        end
        d.irq = |(d.stat & d.mask);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign stat_o = q.stat;
    assign mask_o = q.mask;
    assign irq_o  = q.irq;
endmodule : fsq_irq

// File: design/fsq_pkg.sv
// Package: register map, reset values, modes and states of the sequencer
// ============================================================
// How it works
// RL1: Five filling methods, other codes refused
// RL2: Pulse mode starts a fill on start
// RL3: Next pulse fill needs fresh start while ready
// RL4: Level mode start is a held run level
// RL5: Level held means cycles repeat without events
// RL6: Dropping level start stops automatic filling
// RL7: Level drop finishes current cycle, then ready
// RL8: Batch count loads quantity, decrements per fill
// RL9: Count at zero stops and refuses fills
// RL10: New batch quantity needed for next batch
// RL11: Batch total adds target after each fill
// RL12: Batch total needs total, ends when reached
// RL13: Bulk trims last pack to hit total
// RL14: Bulk needs total, ends when delivered
// RL15: Spare inputs and outputs disabled after reset
// RL16: Closed discharge gate: feed to weight, signal
package fsq_pkg;
    // ============================================================
    // Register byte offsets
    localparam logic [7:0] FSQ_CTRL_OFF      = 8'h00;
    localparam logic [7:0] FSQ_TARGET_OFF    = 8'h04;
    localparam logic [7:0] FSQ_BATCH_OFF     = 8'h08;
    localparam logic [7:0] FSQ_TOTAL_OFF     = 8'h0c;
    localparam logic [7:0] FSQ_REMAIN_OFF    = 8'h10;
    localparam logic [7:0] FSQ_ACCUM_OFF     = 8'h14;
    localparam logic [7:0] FSQ_STATUS_OFF    = 8'h18;
    localparam logic [7:0] FSQ_IRQ_STAT_OFF  = 8'h1c;
    localparam logic [7:0] FSQ_IRQ_MASK_OFF  = 8'h20;
    localparam logic [7:0] FSQ_SPARE_EN_OFF  = 8'h24;
    localparam logic [7:0] FSQ_SPARE_OUT_OFF = 8'h28;
    localparam logic [7:0] FSQ_SPARE_IN_OFF  = 8'h2c;
    // ============================================================
    // Field positions and reset values
    localparam int         FSQ_SPO_EN_POS  = 16;
    localparam int         FSQ_ERR_POS     = 8;
    localparam logic [2:0] FSQ_METHOD_RST  = 3'h0;
    // ============================================================
    // Filling methods
    localparam logic [2:0] FSQ_M_PULSE = 3'h0;
    localparam logic [2:0] FSQ_M_LEVEL = 3'h1;
    localparam logic [2:0] FSQ_M_BATCH = 3'h2;
    localparam logic [2:0] FSQ_M_TOTAL = 3'h3;
    localparam logic [2:0] FSQ_M_BULK  = 3'h4;
    // ============================================================
    // Interrupt events
    localparam int FSQ_N_IRQ     = 4;
    localparam int FSQ_IRQ_FULL  = 0;
    localparam int FSQ_IRQ_DISCH = 1;
    localparam int FSQ_IRQ_BATCH = 2;
    localparam int FSQ_IRQ_ERR   = 3;
    // ============================================================
    // Sequencer states
    typedef enum logic [3:0] {
        FSQ_READY = 4'h1,
        FSQ_FILL  = 4'h2,
        FSQ_FULL  = 4'h4,
        FSQ_DISCH = 4'h8
    } fsq_state_t;
endpackage : fsq_pkg

// File: design/fsq_top.sv
// Module: filling sequencer with APB registers and interrupt
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
module fsq_top #(
    parameter int WW  = 24,
    parameter int CW  = 16,
    parameter int SIW = 10,
    parameter int SOW = 6
) (
    input  wire logic           CLK_SYS_I,
    input  wire logic           RST_I,
    input  wire logic           PSEL_I,
    input  wire logic           PENABLE_I,
    input  wire logic           PWRITE_I,
    input  wire logic [7:0]     PADDR_I,
    input  wire logic [31:0]    PWDATA_I,
    output logic      [31:0]    PRDATA_O,
    output logic                PREADY_O,
    output logic                PSLVERR_O,
    input  wire logic [WW-1:0]  WEIGHT_I,
    input  wire logic           START_FILL_I,
    input  wire logic           START_DISCH_I,
    input  wire logic           DISCH_CLOSED_I,
    input  wire logic           FEED_OPEN_I,
    input  wire logic           RESET_IN_I,
    input  wire logic [SIW-1:0] SPARE_IN_I,
    output logic                READY_O,
    output logic                COARSE_FEED_O,
    output logic                FEED_GATE_O,
    output logic                FEEDING_O,
    output logic                END_FILL_O,
    output logic                DISCH_GATE_O,
    output logic                END_DISCH_O,
    output logic                ERROR_O,
    output logic      [SOW-1:0] SPARE_OUT_O,
    output logic                IRQ_O
);
    localparam int NI = fsq_pkg::FSQ_N_IRQ;

    typedef struct packed {
        fsq_pkg::fsq_state_t state;
        logic [2:0]          method;
        logic [WW-1:0]       target;
        logic [WW-1:0]       total;
        logic [WW-1:0]       accum;
        logic [WW-1:0]       fill_amt;
        logic [CW-1:0]       remain;
        logic                err;
        logic [SIW-1:0]      spi_en;
        logic [SOW-1:0]      spo_en;
        logic [SOW-1:0]      spo_val;
        logic                pready;
        logic                pslverr;
        logic [31:0]         prdata;
        logic                ready;
        logic                feed;
        logic                feed_gate;
        logic                feeding;
        logic                end_fill;
        logic                disch_gate;
        logic                end_disch;
        logic                error;
        logic [SOW-1:0]      spare_o;
    } fsq_main_t;

    fsq_main_t q;
    fsq_main_t n;

    if (WW < 2 || WW > 32 || CW < 1 || CW > 32 || SIW < 1 || SIW > 16
        || SOW < 1 || SOW > 16) begin : g_bad_par
        $error("fsq_top: width parameter out of range");
    end

    // ============================================================
    // Helpers
    logic [1:0]    rise;
    logic          start_rise;
    logic          disch_rise;
    logic [NI-1:0] irq_set;
    logic [NI-1:0] irq_stat;
    logic [NI-1:0] irq_mask;
    logic          irq_q;
    logic          wr;
    logic          rd;
    logic          setup;
    logic          hit;
    logic [31:0]   rdmux;
    logic          go;
    logic          avail;
    logic [WW-1:0] rem_w;
    logic [WW-1:0] accum_n;
    logic [CW-1:0] remain_n;
    logic          mode_tot;

    fsq_edge #(
        .W      (2)
    ) u_edge (
        .clk_i  (CLK_SYS_I),
        .rst_i  (RST_I),
        .sig_i  ({START_DISCH_I, START_FILL_I}),
        .rise_o (rise)
    );

    assign start_rise = rise[0];
    assign disch_rise = rise[1];

    fsq_irq #(
        .N          (NI)
    ) u_irq (
        .clk_i      (CLK_SYS_I),
        .rst_i      (RST_I),
        .set_i      (irq_set),
        .rd_clr_i   (rd && PADDR_I == fsq_pkg::FSQ_IRQ_STAT_OFF),
        .clr_mask_i (q.prdata[NI-1:0]),
        .mask_wr_i  (wr && PADDR_I == fsq_pkg::FSQ_IRQ_MASK_OFF),
        .mask_i     (PWDATA_I[NI-1:0]),
        .stat_o     (irq_stat),
        .mask_o     (irq_mask),
        .irq_o      (irq_q)
    );

    // ============================================================
    // Read mux
    always_comb begin
        hit   = 1'b1;
        rdmux = '0;
        unique case (PADDR_I)
            fsq_pkg::FSQ_CTRL_OFF:      rdmux = 32'(q.method);
            fsq_pkg::FSQ_TARGET_OFF:    rdmux = 32'(q.target);
            fsq_pkg::FSQ_BATCH_OFF:     rdmux = 32'(q.remain);
            fsq_pkg::FSQ_TOTAL_OFF:     rdmux = 32'(q.total);
            fsq_pkg::FSQ_REMAIN_OFF:    rdmux = 32'(q.remain);
            fsq_pkg::FSQ_ACCUM_OFF:     rdmux = 32'(q.accum);
            fsq_pkg::FSQ_STATUS_OFF:
                rdmux = 32'({q.err, 4'h0, q.state});
            fsq_pkg::FSQ_IRQ_STAT_OFF:  rdmux = 32'(irq_stat);
            fsq_pkg::FSQ_IRQ_MASK_OFF:  rdmux = 32'(irq_mask);
            fsq_pkg::FSQ_SPARE_EN_OFF:
                rdmux = (32'(q.spo_en) << fsq_pkg::FSQ_SPO_EN_POS)
                        | 32'(q.spi_en);
            fsq_pkg::FSQ_SPARE_OUT_OFF: rdmux = 32'(q.spo_val);
            fsq_pkg::FSQ_SPARE_IN_OFF:
                rdmux = 32'(SPARE_IN_I & q.spi_en);  // RL15
            default:                    hit = 1'b0;
        endcase
    end

    // ============================================================
    // Next state
    always_comb begin
        n        = q;
        irq_set  = '0;
        setup    = PSEL_I & ~PENABLE_I;
        wr       = PSEL_I & PENABLE_I & q.pready & PWRITE_I;
        rd       = PSEL_I & PENABLE_I & q.pready & ~PWRITE_I;
        mode_tot = (q.method == fsq_pkg::FSQ_M_TOTAL)
                   || (q.method == fsq_pkg::FSQ_M_BULK);
        rem_w    = WW'(q.total - q.accum);
        accum_n  = WW'(q.accum + q.fill_amt);
        remain_n = CW'(q.remain - 1'b1);
        // Answer one cycle after setup: a single wait-free access
        n.pready  = setup;
        n.pslverr = setup & ~hit;
        n.prdata  = (setup & ~PWRITE_I) ? rdmux : '0;
        n.end_disch = 1'b0;

        if (wr) begin
            unique case (PADDR_I)
                fsq_pkg::FSQ_CTRL_OFF:
                    if (PWDATA_I[2:0] <= fsq_pkg::FSQ_M_BULK) begin
                        n.method = PWDATA_I[2:0];  // RL1
                    end
                fsq_pkg::FSQ_TARGET_OFF:
                    n.target = PWDATA_I[WW-1:0];
                fsq_pkg::FSQ_BATCH_OFF:
                    n.remain = PWDATA_I[CW-1:0];  // RL8 RL10
                fsq_pkg::FSQ_TOTAL_OFF: begin
                    n.total = PWDATA_I[WW-1:0];  // RL12 RL14
                    n.accum = '0;
                end
                fsq_pkg::FSQ_SPARE_EN_OFF: begin
                    n.spi_en = PWDATA_I[SIW-1:0];
                    n.spo_en = PWDATA_I[fsq_pkg::FSQ_SPO_EN_POS +: SOW];
                end
                fsq_pkg::FSQ_SPARE_OUT_OFF:
                    n.spo_val = PWDATA_I[SOW-1:0];
                default: ;
            endcase
        end

        unique case (q.method)
            fsq_pkg::FSQ_M_BATCH: avail = q.remain != '0;  // RL9
            fsq_pkg::FSQ_M_TOTAL,
            fsq_pkg::FSQ_M_BULK:  avail = q.accum < q.total;  // RL12 RL14
            default:              avail = 1'b1;
        endcase
        if (q.method == fsq_pkg::FSQ_M_LEVEL) begin
            go = START_FILL_I;  // RL5 RL6
        end else begin
            go = start_rise & avail;  // RL2 RL3
        end

        unique case (q.state)
            fsq_pkg::FSQ_READY: begin
                if (go && !q.err) begin
                    if (!DISCH_CLOSED_I) begin
                        n.err = 1'b1;  // RL16
                        irq_set[fsq_pkg::FSQ_IRQ_ERR] = 1'b1;
                    end else begin
                        n.state    = fsq_pkg::FSQ_FILL;  // RL16
                        n.fill_amt = q.target;
                        if (q.method == fsq_pkg::FSQ_M_BULK
                            && rem_w < q.target) begin
                            n.fill_amt = rem_w;  // RL13
                        end
                    end
                end
            end
            fsq_pkg::FSQ_FILL: begin
                if (!DISCH_CLOSED_I) begin
                    // Gate opened under a filling hopper: stop at once
                    n.err   = 1'b1;
                    n.state = fsq_pkg::FSQ_READY;
                    irq_set[fsq_pkg::FSQ_IRQ_ERR] = 1'b1;
                end else if (WEIGHT_I >= q.fill_amt) begin
                    n.state = fsq_pkg::FSQ_FULL;  // RL16
                    irq_set[fsq_pkg::FSQ_IRQ_FULL] = 1'b1;
                end
            end
            fsq_pkg::FSQ_FULL: begin
                if (disch_rise) begin
                    n.state = fsq_pkg::FSQ_DISCH;
                end
            end
            fsq_pkg::FSQ_DISCH: begin
                // Runs to empty whatever the level start does
                if (WEIGHT_I == '0) begin
                    n.state     = fsq_pkg::FSQ_READY;  // RL7
                    n.end_disch = 1'b1;
                    irq_set[fsq_pkg::FSQ_IRQ_DISCH] = 1'b1;
                    if (q.method == fsq_pkg::FSQ_M_BATCH) begin
                        n.remain = remain_n;  // RL8
                        if (remain_n == '0) begin
                            irq_set[fsq_pkg::FSQ_IRQ_BATCH] = 1'b1;
                        end
                    end else if (mode_tot) begin
                        n.accum = accum_n;  // RL11 RL13
                        if (accum_n >= q.total) begin
                            irq_set[fsq_pkg::FSQ_IRQ_BATCH] = 1'b1;
                        end
                    end
                end
            end
        endcase

        // Reset input aborts the cycle and clears the error
        if (RESET_IN_I) begin
            n.state     = fsq_pkg::FSQ_READY;
            n.err       = 1'b0;
            n.end_disch = 1'b0;
        end

        n.ready      = (n.state == fsq_pkg::FSQ_READY) & ~n.err & avail;
        n.feed       = n.state == fsq_pkg::FSQ_FILL;
        n.feed_gate  = n.state == fsq_pkg::FSQ_FILL;
        n.feeding    = (n.state == fsq_pkg::FSQ_FILL) & FEED_OPEN_I;
        n.end_fill   = n.state == fsq_pkg::FSQ_FULL;
        n.disch_gate = n.state == fsq_pkg::FSQ_DISCH;
        n.error      = n.err;
        n.spare_o    = n.spo_val & n.spo_en;  // RL15
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            q        <= '0;
            q.state  <= fsq_pkg::FSQ_READY;
            q.method <= fsq_pkg::FSQ_METHOD_RST;
        end else begin
            q <= n;
        end
    end

    // ============================================================
    // Outputs
    assign PRDATA_O      = q.prdata;
    assign PREADY_O      = q.pready;
    assign PSLVERR_O     = q.pslverr;
    assign READY_O       = q.ready;
    assign COARSE_FEED_O = q.feed;
    assign FEED_GATE_O   = q.feed_gate;
    assign FEEDING_O     = q.feeding;
    assign END_FILL_O    = q.end_fill;
    assign DISCH_GATE_O  = q.disch_gate;
    assign END_DISCH_O   = q.end_disch;
    assign ERROR_O       = q.error;
    assign SPARE_OUT_O   = q.spare_o;
    assign IRQ_O         = irq_q;

    // ============================================================
    // Assertions
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (RST_I);

    sequence s_empty_done;
        q.state == fsq_pkg::FSQ_DISCH && WEIGHT_I == '0 && !RESET_IN_I;
    endsequence

    sequence s_no_total_wr;
        !(wr && PADDR_I == fsq_pkg::FSQ_TOTAL_OFF);
    endsequence

    a_method_legal: assert property ( // RL1
        q.method <= fsq_pkg::FSQ_M_BULK)
        else $error("illegal filling method held");

    a_pulse_fresh: assert property ( // RL2 RL3
        $rose(FEED_GATE_O) && q.method == fsq_pkg::FSQ_M_PULSE
        |-> $past(START_FILL_I) && !$past(START_FILL_I, 2))
        else $error("pulse fill began without a fresh start");

    a_level_repeat: assert property ( // RL5
        q.state == fsq_pkg::FSQ_READY && q.method == fsq_pkg::FSQ_M_LEVEL
        && START_FILL_I && DISCH_CLOSED_I && !q.err && !RESET_IN_I
        |=> FEED_GATE_O)
        else $error("level start did not repeat the fill");

    a_level_stop: assert property ( // RL6
        q.state == fsq_pkg::FSQ_READY && q.method == fsq_pkg::FSQ_M_LEVEL
        && !START_FILL_I |=> !FEED_GATE_O)
        else $error("fill began with level start removed");

    a_level_finish: assert property ( // RL7
        q.state == fsq_pkg::FSQ_DISCH && !START_FILL_I
        && WEIGHT_I != '0 && !RESET_IN_I |=> DISCH_GATE_O)
        else $error("cycle aborted on level start removal");

    a_batch_count: assert property ( // RL8
        s_empty_done ##0 s_no_total_wr
        ##0 q.method == fsq_pkg::FSQ_M_BATCH
        ##0 !(wr && PADDR_I == fsq_pkg::FSQ_BATCH_OFF)
        |=> q.remain == CW'($past(q.remain) - 1'b1))
        else $error("batch count not decremented");

    a_batch_stop: assert property ( // RL9
        q.state == fsq_pkg::FSQ_READY && q.method == fsq_pkg::FSQ_M_BATCH
        && q.remain == '0 |=> !FEED_GATE_O && !READY_O)
        else $error("fill began with batch exhausted");

    a_total_add: assert property ( // RL11
        s_empty_done ##0 s_no_total_wr
        ##0 q.method == fsq_pkg::FSQ_M_TOTAL
        |=> q.accum == WW'($past(q.accum) + $past(q.target)))
        else $error("target not added to total");

    a_total_end: assert property ( // RL12 RL14
        q.state == fsq_pkg::FSQ_READY && mode_tot && q.accum >= q.total
        |=> !FEED_GATE_O)
        else $error("fill began with total reached");

    a_bulk_last: assert property ( // RL13
        $rose(FEED_GATE_O) && q.method == fsq_pkg::FSQ_M_BULK
        |-> q.fill_amt <= q.target
        && 33'(q.accum) + 33'(q.fill_amt) <= 33'(q.total))
        else $error("bulk pack overshoots the total");

    a_spare_off: assert property ( // RL15
        (SPARE_OUT_O & ~q.spo_en) == '0)
        else $error("disabled spare output driven");

    a_gate_closed: assert property ( // RL16
        $rose(FEED_GATE_O) |-> $past(DISCH_CLOSED_I))
        else $error("feeding began with discharge gate open");

    a_fill_end: assert property ( // RL16
        q.state == fsq_pkg::FSQ_FILL && WEIGHT_I >= q.fill_amt
        && DISCH_CLOSED_I && !RESET_IN_I
        |=> END_FILL_O && !FEED_GATE_O ##1 END_FILL_O || DISCH_GATE_O)
        else $error("feeding not closed at filling weight");
endmodule : fsq_top

// File: tb/fsq_machine.sv
// Behavioural filling machine: hopper weight, gates, discharge start
`timescale 1ns/1ps
module fsq_machine (
    input  wire logic        clk_i,
    input  wire logic        feed_gate_i,
    input  wire logic        disch_gate_i,
    input  wire logic        end_fill_i,
    input  wire logic        jam_i,
    input  wire logic [1:0]  step_i,
    output logic      [23:0] weight_o,
    output logic             feed_open_o,
    output logic             disch_closed_o,
    output logic             start_disch_o
);
    // ============================================================
    // Hopper
    initial begin
        weight_o      = '0;
        feed_open_o   = 1'b0;
        start_disch_o = 1'b0;
    end
    // Jam models a stuck-open discharge gate for the error case
    assign disch_closed_o = !disch_gate_i && !jam_i;
    // Step sets the flow: 0 is a slow feeder, 3 a fast one
    always @(posedge clk_i) begin
        feed_open_o   <= feed_gate_i;
        start_disch_o <= end_fill_i && !start_disch_o;
        if (feed_gate_i) begin
            weight_o <= weight_o + 24'(step_i) + 24'h1;
        end else if (disch_gate_i) begin
            weight_o <= (weight_o > 24'(step_i) + 24'h1) ?
                        weight_o - 24'(step_i) - 24'h1 : '0;
        end
    end
endmodule : fsq_machine

// File: tb/fsq_top_tb.sv
// Self-checking testbench of the filling sequencer
`timescale 1ns/1ps
module fsq_top_tb;
    logic        clk, rst, psel, pen, pwr, start, rin, jam, perr_q;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prd_q;
    logic [1:0]  step;
    logic [9:0]  spin;
    logic [23:0] weight, e;
    logic        efill_q;
    wire  [31:0] prdata;
    wire         pready, pslverr, dclosed, fopen, sdisch, rdy, coarse;
    wire         fgate, feeding, efill, dgate, edisch, err, irq;
    wire  [5:0]  spout;
    int          failures, tests_run;
    logic [23:0] expq[$];

    fsq_top i_dut (.CLK_SYS_I(clk), .RST_I(rst), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .WEIGHT_I(weight), .START_FILL_I(start),
        .START_DISCH_I(sdisch), .DISCH_CLOSED_I(dclosed),
        .FEED_OPEN_I(fopen), .RESET_IN_I(rin), .SPARE_IN_I(spin),
        .READY_O(rdy), .COARSE_FEED_O(coarse), .FEED_GATE_O(fgate),
        .FEEDING_O(feeding), .END_FILL_O(efill), .DISCH_GATE_O(dgate),
        .END_DISCH_O(edisch), .ERROR_O(err), .SPARE_OUT_O(spout),
        .IRQ_O(irq));
    fsq_machine i_mach (.clk_i(clk), .feed_gate_i(fgate),
        .disch_gate_i(dgate), .end_fill_i(efill), .jam_i(jam),
        .step_i(step), .weight_o(weight), .feed_open_o(fopen),
        .disch_closed_o(dclosed), .start_disch_o(sdisch));

    // ============================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] ex);
        tests_run++;
        if (got !== ex) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, ex);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // Answer is taken at the very edge that samples pready high
        do @(posedge clk); while (pready !== 1'b1);
        prd_q  = prdata;
        perr_q = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        chk(prd_q, ex);
        chk(perr_q, 0);
    endtask : rdchk

    task automatic wt(input int k);
        logic [3:0] v;
        // No limit of its own: a hang is caught by the watchdog
        do begin
            @(negedge clk);
            v = {dgate, err, fgate, edisch};
        end while (v[k] !== 1'b1);
    endtask : wt

    task automatic fill(input logic [23:0] amt);
        expq.push_back(amt);
        @(posedge clk);
        step  <= 2'($urandom_range(3, 0));
        start <= 1'b1;
        wt(0);
        @(posedge clk);
        start <= 1'b0;
        repeat (4) @(negedge clk);
        chk(fgate, 0);
    endtask : fill

    task automatic refuse();
        @(posedge clk);
        start <= 1'b1;
        repeat (8) @(negedge clk);
        chk({fgate, rdy}, 0);
        @(posedge clk);
        start <= 1'b0;
    endtask : refuse

    task automatic summarize();
        if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    // ============================================================
    // Monitor: each end of fill takes the oldest expected amount
    always @(negedge clk) begin
        if (efill === 1'b1 && efill_q !== 1'b1) begin
            e = expq.size() > 0 ? expq.pop_front() : 24'hffffff;
            chk(weight >= e && weight < e + 8, 1);
        end
        efill_q = efill;
    end

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        summarize();
    end

    // ============================================================
    // Main sequence
    initial begin
        {rst, psel, pen, pwr, start, rin, jam} = 7'h40;
        {paddr, pwdata, step, spin} = '0;
        {failures, tests_run} = '0;
        void'($urandom(32'h2867));
        repeat (20) @(posedge clk);
        rst  <= 1'b0;
        spin <= 10'($urandom());
        rdchk(fsq_pkg::FSQ_SPARE_EN_OFF, 0);
        rdchk(fsq_pkg::FSQ_SPARE_IN_OFF, 0);
        chk(spout, 0);
        apb(1'b1, fsq_pkg::FSQ_SPARE_EN_OFF, 32'h003f03ff);
        apb(1'b1, fsq_pkg::FSQ_SPARE_OUT_OFF, 32'h2a);
        @(negedge clk);
        chk(spout, 6'h2a);
        rdchk(fsq_pkg::FSQ_SPARE_IN_OFF, spin);
        apb(1'b0, 8'h3c, 32'h0);
        chk(prd_q, 0);
        chk(perr_q, 1);
        for (int m = 0; m < 6; m++) begin
            apb(1'b1, fsq_pkg::FSQ_CTRL_OFF, m);
            rdchk(fsq_pkg::FSQ_CTRL_OFF, m > 4 ? 4 : m);
        end
        apb(1'b1, fsq_pkg::FSQ_CTRL_OFF, fsq_pkg::FSQ_M_PULSE);
        apb(1'b1, fsq_pkg::FSQ_TARGET_OFF, 10);
        fill(10);
        fill(10);
        chk(irq, 0);
        apb(1'b1, fsq_pkg::FSQ_IRQ_MASK_OFF, 2);
        @(negedge clk);
        chk(irq, 1);
        rdchk(fsq_pkg::FSQ_IRQ_STAT_OFF, 3);
        @(negedge clk);
        chk(irq, 0);
        apb(1'b1, fsq_pkg::FSQ_CTRL_OFF, fsq_pkg::FSQ_M_BATCH);
        apb(1'b1, fsq_pkg::FSQ_BATCH_OFF, 2);
        fill(10);
        fill(10);
        rdchk(fsq_pkg::FSQ_REMAIN_OFF, 0);
        refuse();
        rdchk(fsq_pkg::FSQ_IRQ_STAT_OFF, 7);
        apb(1'b1, fsq_pkg::FSQ_BATCH_OFF, 1);
        repeat (2) @(negedge clk);
        chk(rdy, 1);
        fill(10);
        refuse();
        apb(1'b1, fsq_pkg::FSQ_CTRL_OFF, fsq_pkg::FSQ_M_TOTAL);
        apb(1'b1, fsq_pkg::FSQ_TOTAL_OFF, 20);
        fill(10);
        fill(10);
        rdchk(fsq_pkg::FSQ_ACCUM_OFF, 20);
        refuse();
        apb(1'b1, fsq_pkg::FSQ_CTRL_OFF, fsq_pkg::FSQ_M_BULK);
        apb(1'b1, fsq_pkg::FSQ_TOTAL_OFF, 25);
        fill(10);
        fill(10);
        fill(5);
        rdchk(fsq_pkg::FSQ_ACCUM_OFF, 25);
        refuse();
        apb(1'b1, fsq_pkg::FSQ_CTRL_OFF, fsq_pkg::FSQ_M_LEVEL);
        expq.push_back(10);
        expq.push_back(10);
        @(posedge clk);
        start <= 1'b1;
        wt(0);
        wt(1);
        chk({coarse, dgate}, 2'b10);
        @(posedge clk);
        start <= 1'b0;
        repeat (2) @(negedge clk);
        chk(feeding, 1);
        wt(3);
        chk({efill, coarse}, 0);
        wt(0);
        repeat (20) @(negedge clk);
        chk({fgate, rdy}, 1);
        chk(32'(expq.size()), 0);
        apb(1'b1, fsq_pkg::FSQ_CTRL_OFF, fsq_pkg::FSQ_M_PULSE);
        apb(1'b0, fsq_pkg::FSQ_IRQ_STAT_OFF, 32'h0);
        apb(1'b1, fsq_pkg::FSQ_IRQ_MASK_OFF, 8);
        @(posedge clk);
        jam   <= 1'b1;
        start <= 1'b1;
        wt(2);
        @(negedge clk);
        chk({err, fgate, irq}, 3'b101);
        rdchk(fsq_pkg::FSQ_IRQ_STAT_OFF, 8);
        @(posedge clk);
        rin   <= 1'b1;
        jam   <= 1'b0;
        start <= 1'b0;
        @(posedge clk);
        rin <= 1'b0;
        @(negedge clk);
        chk({err, rdy}, 1);
        summarize();
    end
endmodule : fsq_top_tb
